/* hdl/sacs_scheduler.sv */
// Conversion scheduler for a six-channel simultaneous-sampling converter, three pairs.
// Assumes conv_clk, hold and read pins are synchronous to clock; results come from converters.
//
// How it works
// - Reset clears outputs, aborts conversion, resamples
// - Busy low from start, 12.5 cycles, until latched
// - Conversion slot spans at least 16 cycles
// - Hold edge freezes pair; convert when free
// - New holds queue behind earlier pending pairs
// - Same-cycle holds convert A, then B, then C
// - Holds counted at falling conversion-clock edge
// - Only falling hold edges start conversions
// - Further edges ignored until pair converts
// - Previous result readable during next conversion
// - Select 010 gives B0, 011 gives B1
// - Outputs driven only while select and strobe low
// - Result latched 12.5 cycles after busy falls
// - Word: valid bit15, channel 14:12, data 11:0
// - Select 110 cycles channels; 111 is FIFO
// - Latch waits while a read is active
// - Two converters convert both pair channels together
`timescale 1ns/1ps
`include "sacs_map.svh"
module sacs_scheduler
    import sacs_pkg::*;
(
    input  wire logic        clock,                   // System clock, 250 MHz
    input  wire logic        rst_n,                   // Sync reset, low
    input  wire logic        conv_clk,                // Conversion clock, sampled
    input  wire logic        pair_a_sample_request_n, // Pair A hold, low
    input  wire logic        pair_b_sample_request_n, // Pair B hold, low
    input  wire logic        pair_c_sample_request_n, // Pair C hold, low
    input  wire logic [11:0] conv0_result,            // Converter 0 result
    input  wire logic [11:0] conv1_result,            // Converter 1 result
    input  wire logic        chip_select_n,           // Chip select, low
    input  wire logic        read_strobe_n,           // Read strobe, low
    input  wire logic [2:0]  result_select_lines,     // Channel or mode select
    output logic             busy_n,                  // Conversion busy, low
    output logic [2:0]       hold_pairs,              // Pairs frozen (A,B,C bits 0..2)
    output logic [1:0]       conv_pair,               // Pair on converter input mux
    output logic [15:0]      data_out,                // Read port data
    output logic [15:0]      data_oe                  // Read port enable, high drives
);
    // ****************************************************************
    // Pin sampling and edge detection
    // ****************************************************************
    logic [2:0] hold_n;
    logic [2:0] hold_prev_q, hold_prev_d;
    logic       cclk_q, cclk_d, rd_q, rd_d;
    logic       cclk_fall, cclk_rise, reading, rd_end;

    always_comb begin
        hold_n      = {pair_c_sample_request_n, pair_b_sample_request_n,
                       pair_a_sample_request_n};
        hold_prev_d = hold_n;
        cclk_d      = conv_clk;
        reading     = !chip_select_n && !read_strobe_n;
        rd_d        = reading;
        cclk_fall   = cclk_q && !conv_clk;
        cclk_rise   = !cclk_q && conv_clk;
        rd_end      = rd_q && !reading;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hold_prev_q <= 3'h7;
            cclk_q      <= 1'b0;
            rd_q        <= 1'b0;
        end else begin
            hold_prev_q <= hold_prev_d;
            cclk_q      <= cclk_d;
            rd_q        <= rd_d;
        end
    end

    // ****************************************************************
    // Edge capture, pending flags and priority pick
    // ****************************************************************
    // Edges between conversion-clock falls collect here, then commit together,
    // so the pair order reflects the cycle, not the nanosecond.
    logic [2:0]  seen_q, seen_d, pend_q, pend_d, held_q, held_d;
    logic [2:0]  start_pick;
    logic [2:0]  fresh, freed, oldest, lvl;
    logic [5:0]  age_q, age_d;
    logic        start;
    sacs_state_t st_q, st_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [1:0]  pair_q, pair_d;

    function automatic logic [2:0] first_pair(input logic [2:0] req);
        first_pair = req[0] ? 3'h1 : req[1] ? 3'h2 : req[2] ? 3'h4 : 3'h0;
    endfunction

    function automatic logic [1:0] pair_index(input logic [2:0] onehot);
        pair_index = onehot[2] ? 2'h2 : onehot[1] ? 2'h1 : 2'h0;
    endfunction

    always_comb begin
        // Freeze released when that pair's conversion completes; an edge in
        // that same cycle still counts, so a new hold wins over the release
        freed = (st_q == SACS_STORE && st_d == SACS_ACQ) ? (3'h1 << pair_q) : 3'h0;
        // Falling edges only; a held-low input never re-arms
        fresh  = hold_prev_q & ~hold_n;
        seen_d = seen_q | (fresh & ~(held_q & ~freed));
        held_d = (held_q & ~freed) | fresh;
        pend_d = pend_q;
        age_d  = age_q;
        if (cclk_fall) begin
            // Pairs still waiting grow older than those committing now
            if (seen_d != 3'h0) begin
                for (int i = 0; i < 3; i++) begin
                    age_d[2*i +: 2] = pend_q[i] ? age_q[2*i +: 2] + 2'h1 : 2'h0;
                end
            end
            pend_d = pend_q | seen_d;
            seen_d = 3'h0;
        end
        // Oldest commit goes first; inside one commit A, B, C
        oldest = 3'h0;
        lvl    = 3'h0;
        for (int a = 0; a < 3; a++) begin
            for (int i = 0; i < 3; i++) begin
                lvl[i] = pend_q[i] && (age_q[2*i +: 2] == 2'(a));
            end
            if (lvl != 3'h0) begin
                oldest = lvl;
            end
        end
        start_pick = first_pair(oldest);
        start      = (st_q == SACS_IDLE) && cclk_rise && (pend_q != 3'h0);
        if (start) begin
            pend_d = pend_d & ~start_pick;
        end
    end

    // ****************************************************************
    // Conversion sequencer
    // ****************************************************************
    // cnt counts conversion-clock half periods from busy falling.
    logic        latch_now;
    logic        fifo_in_ready;
    logic [4:0]  slot_q, slot_d;

    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        pair_d    = pair_q;
        slot_d    = slot_q;
        latch_now = 1'b0;
        if (st_q != SACS_IDLE && (cclk_fall || cclk_rise)) begin
            cnt_d  = cnt_q + 5'h1;
            slot_d = slot_q + 5'h1;
        end
        case (st_q)
            SACS_IDLE: begin
                if (start) begin
                    st_d   = SACS_CONV;
                    pair_d = pair_index(start_pick);
                    cnt_d  = 5'h0;
                    slot_d = 5'h0;
                end
            end
            SACS_CONV: begin
                if (cnt_d == 5'(`SACS_LATCH_HALVES)) begin
                    st_d = SACS_STORE;
                end
            end
            SACS_STORE: begin
                // A read in progress defers the latch until strobe rises
                if (!reading && fifo_in_ready) begin
                    latch_now = 1'b1;
                    st_d      = SACS_ACQ;
                end
            end
            SACS_ACQ: begin
                // Acquisition fills the slot to the full count
                if (slot_q >= 5'(2 * `SACS_SLOT_CYCLES - 2)) begin
                    st_d = SACS_IDLE;
                end
            end
            default: begin
                st_d = SACS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q   <= SACS_IDLE;
            cnt_q  <= 5'h0;
            slot_q <= 5'h0;
            pair_q <= 2'h0;
            seen_q <= 3'h0;
            pend_q <= 3'h0;
            held_q <= 3'h0;
            age_q  <= 6'h00;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            slot_q <= slot_d;
            pair_q <= pair_d;
            seen_q <= seen_d;
            pend_q <= pend_d;
            held_q <= held_d;
            age_q  <= age_d;
        end
    end

    // ****************************************************************
    // Result registers and FIFO store
    // ****************************************************************
    // Both channels of a pair are stored in one latch event
    logic [11:0] res_q [6];
    logic [11:0] res_d [6];
    logic [5:0]  vld_q, vld_d;
    logic [15:0] fifo_in, fifo_out;
    logic        fifo_in_valid, fifo_out_valid, fifo_pop;
    logic        push_second_q, push_second_d;
    logic [11:0] second_q, second_d;

    always_comb begin
        vld_d         = vld_q;
        second_d      = second_q;
        push_second_d = 1'b0;
        for (int i = 0; i < 6; i++) begin
            res_d[i] = res_q[i];
        end
        if (latch_now) begin
            res_d[2*pair_q]     = conv0_result;
            res_d[2*pair_q + 1] = conv1_result;
            vld_d[2*pair_q]     = 1'b1;
            vld_d[2*pair_q + 1] = 1'b1;
            second_d            = conv1_result;
            push_second_d       = 1'b1;
        end
        fifo_in_valid = latch_now || push_second_q;
        fifo_in = latch_now ?
            {1'b1, 3'(2 * pair_q), conv0_result} :
            {1'b1, 3'(2 * pair_q + 1), second_q};
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            vld_q         <= 6'h0;
            push_second_q <= 1'b0;
            second_q      <= 12'h000;
            for (int i = 0; i < 6; i++) begin
                res_q[i] <= 12'h000;
            end
        end else begin
            vld_q         <= vld_d;
            push_second_q <= push_second_d;
            second_q      <= second_d;
            for (int i = 0; i < 6; i++) begin
                res_q[i] <= res_d[i];
            end
        end
    end

    // Store holds far more than six words; a second push that meets a full FIFO,
    // as when the first push took the last place, is dropped.
    sacs_fifo #(.WIDTH(`SACS_WORD_W), .DEPTH(`SACS_FIFO_DEPTH)) sacs_fifo_inst (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_data   (fifo_in),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    // ****************************************************************
    // Read port
    // ****************************************************************
    logic [2:0]  cyc_q, cyc_d;
    logic [2:0]  sel;
    logic [15:0] word;
    logic [15:0] dout_d, doe_d;
    logic        busy_d;
    logic [2:0]  hold_d;
    logic [1:0]  mux_d;

    always_comb begin
        sel      = result_select_lines;
        fifo_pop = rd_end && (sel == `SACS_SEL_FIFO) && fifo_out_valid;
        cyc_d    = cyc_q;
        if (rd_end && sel == `SACS_SEL_CYCLE) begin
            cyc_d = (cyc_q == 3'h5) ? 3'h0 : cyc_q + 3'h1;
        end
        // Direct codes map channel n to word n, 010 is B0, 011 is B1
        case (sel)
            `SACS_SEL_CYCLE: word = {vld_q[cyc_q], cyc_q, res_q[cyc_q]};
            `SACS_SEL_FIFO:  word = fifo_out_valid ? fifo_out : 16'h0000;
            3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: begin
                word = {vld_q[sel], sel, res_q[sel]};
            end
            default: word = 16'h0000;
        endcase
        dout_d = reading ? word : 16'h0000;
        doe_d  = reading ? 16'hFFFF : 16'h0000;
        busy_d = !(st_d == SACS_CONV || st_d == SACS_STORE);
        hold_d = held_d;
        mux_d  = pair_d;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cyc_q      <= 3'h0;
            data_out   <= 16'h0000;
            data_oe    <= 16'h0000;
            busy_n     <= 1'b1;
            hold_pairs <= 3'h0;
            conv_pair  <= 2'h0;
        end else begin
            cyc_q      <= cyc_d;
            data_out   <= dout_d;
            data_oe    <= doe_d;
            busy_n     <= busy_d;
            hold_pairs <= hold_d;
            conv_pair  <= mux_d;
        end
    end
endmodule

/* include/sacs_map.svh */
// Constants for the six-channel conversion scheduler: timing counts, field positions, codes.
// Assumes a 250 MHz system clock; the conversion clock arrives as a sampled input.
`ifndef SACS_MAP_SVH
`define SACS_MAP_SVH

// Conversion timing in conversion-clock cycles and half periods
`define SACS_BUSY_CYCLES     13
`define SACS_SLOT_CYCLES     16
`define SACS_LATCH_HALVES    25
// Output word layout
`define SACS_VALID_BIT       15
`define SACS_CHAN_HI         14
`define SACS_CHAN_LO         12
`define SACS_DATA_HI         11
// Result-select codes
`define SACS_SEL_CYCLE       3'h6
`define SACS_SEL_FIFO        3'h7
// Output word store
`define SACS_FIFO_DEPTH      32
`define SACS_WORD_W          16

`endif

/* include/sacs_pkg.sv */
// Types for the six-channel conversion scheduler.
// Assumes sacs_map.svh is compiled alongside.
package sacs_pkg;
    typedef enum logic [3:0] {
        SACS_IDLE  = 4'h1,
        SACS_CONV  = 4'h2,
        SACS_STORE = 4'h4,
        SACS_ACQ   = 4'h8
    } sacs_state_t;
endpackage

/* hdl/sacs_fifo.sv */
// Word store between conversion results and the read port.
// Assumes a single clock; pop and push may happen in one cycle.
`timescale 1ns/1ps
module sacs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,     // System clock
    input  wire logic             rst_n,     // Sync reset, low
    input  wire logic [WIDTH-1:0] in_data,   // Word to store
    input  wire logic             in_valid,  // Word present
    output logic                  in_ready,  // Room left
    output logic      [WIDTH-1:0] out_data,  // Oldest word
    output logic                  out_valid, // Not empty
    input  wire logic             out_ready  // Consumer takes word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // Pointer arithmetic
    always_comb begin
        push  = in_valid && in_ready;
        pop   = out_valid && out_ready;
        wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Register pointers and storage
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
endmodule

/* verif/sacs_scheduler_monitor.sv */
// Checker of scheduler ports: read enables, busy span, start spacing, pair freezing.
// Assumes binding onto sacs_scheduler and conv_clk toggling every HALF clocks.
`timescale 1ns/1ps
module sacs_scheduler_monitor #(
    parameter int HALF = 16 // Conv clock half period
) (
    input wire logic        clock,                   // Clock
    input wire logic        rst_n,                   // Reset, low
    input wire logic        pair_a_sample_request_n, // Hold A
    input wire logic        pair_b_sample_request_n, // Hold B
    input wire logic        pair_c_sample_request_n, // Hold C
    input wire logic        chip_select_n,           // Select
    input wire logic        read_strobe_n,           // Strobe
    input wire logic        busy_n,                  // Busy
    input wire logic [2:0]  hold_pairs,              // Frozen pairs
    input wire logic [1:0]  conv_pair,               // Pair converting
    input wire logic [15:0] data_out,                // Read data
    input wire logic [15:0] data_oe                  // Read enable
);
    // ********************************
    // Helper counters
    // ********************************
    localparam int LAT_MIN  = 25 * HALF - 4;
    localparam int LAT_MAX  = 25 * HALF + 4;
    localparam int SLOT_MIN = 32 * HALF - 4;
    logic [15:0] low_q, low_d, gap_q, gap_d;
    logic        seen_q, seen_d, prev_q, prev_d;
    logic [2:0]  req_n;
    assign req_n = {pair_c_sample_request_n, pair_b_sample_request_n, pair_a_sample_request_n};
    // Busy span, read seen while busy, gap between starts (saturates)
    always_comb begin
        low_d  = busy_n ? 16'h0000 : low_q + 16'h0001;
        seen_d = !busy_n && (seen_q || (!chip_select_n && !read_strobe_n));
        prev_d = busy_n;
        gap_d  = (prev_q && !busy_n) ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hFFFF};
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            low_q  <= 16'h0000;
            seen_q <= 1'b0;
            prev_q <= 1'b1;
            gap_q  <= 16'hFFFF;
        end else begin
            low_q  <= low_d;
            seen_q <= seen_d;
            prev_q <= prev_d;
            gap_q  <= gap_d;
        end
    end
    // ********************************
    // Port relations
    // ********************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_oe_off;
        (chip_select_n || read_strobe_n) |=> data_oe == 16'h0000 && data_out == 16'h0000;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("read port driven while idle");
    property p_oe_on; (!chip_select_n && !read_strobe_n) |=> data_oe == 16'hFFFF; endproperty
    a_oe_on: assert property (p_oe_on) else $error("read port not driven");
    property p_busy_len;
        $rose(busy_n) |-> low_q >= LAT_MIN && (low_q <= LAT_MAX || seen_q);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy span wrong");
    property p_slot; $fell(busy_n) |-> gap_q >= SLOT_MIN; endproperty
    a_slot: assert property (p_slot) else $error("starts too close");
    property p_start_pending; $fell(busy_n) |-> hold_pairs[conv_pair]; endproperty
    a_start_pending: assert property (p_start_pending)
        else $error("start without hold");
    property p_hold_clear;
        (($past(hold_pairs) & ~hold_pairs) != 3'h0) |-> $rose(busy_n);
    endproperty
    a_hold_clear: assert property (p_hold_clear) else $error("hold released early");
    property p_hold_set;
        (hold_pairs & ~$past(hold_pairs) & req_n & $past(req_n)) == 3'h0;
    endproperty
    a_hold_set: assert property (p_hold_set) else $error("hold without request");
    property p_defer;
        (!busy_n && !chip_select_n && !read_strobe_n && !$past(chip_select_n)
            && !$past(read_strobe_n)) |=> !busy_n;
    endproperty
    a_defer: assert property (p_defer) else $error("latch during read");
endmodule

/* verif/sacs_host_model.sv */
// Far-side stand-in: conversion clock and converter results.
// Assumes the bench holds base steady while a conversion runs.
`timescale 1ns/1ps
module sacs_host_model #(
    parameter int HALF = 16 // Half period in clocks
) (
    input  wire logic        clock,        // System clock
    input  wire logic        rst_n,        // Reset, low
    input  wire logic [1:0]  conv_pair,    // Pair converting
    input  wire logic [11:0] base,         // Result offset
    output logic             conv_clk,     // Conversion clock
    output logic [11:0]      conv0_result, // Channel 0
    output logic [11:0]      conv1_result  // Channel 1
);
    // ********************************
    // Conversion clock
    // ********************************
    logic [7:0] tick_q, tick_d;
    logic       clk_q, clk_d;
    // 128 ns period keeps it under 8 MHz, 64 ns per phase
    always_comb begin
        tick_d = (tick_q == 8'(HALF - 1)) ? 8'h00 : tick_q + 8'h01;
        clk_d  = (tick_q == 8'(HALF - 1)) ? !clk_q : clk_q;
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tick_q <= 8'h00;
            clk_q  <= 1'b1;
        end else begin
            tick_q <= tick_d;
            clk_q  <= clk_d;
        end
    end
    assign conv_clk = clk_q;
    // Channel c of pair p reads base + 2p + c, easy to predict
    assign conv0_result = base + {9'h000, conv_pair, 1'b0};
    assign conv1_result = base + {9'h000, conv_pair, 1'b1};
endmodule

/* verif/sacs_scheduler_test.sv */
// Self-checking bench of the conversion scheduler with its far-side model.
// Assumes the monitor is bound below; inputs change on falling clock edges.
`timescale 1ns/1ps
module sacs_scheduler_test;
    logic        clock, rst_n, conv_clk, busy_n, b, extra;
    logic        pair_a_sample_request_n, pair_b_sample_request_n, pair_c_sample_request_n;
    logic        chip_select_n, read_strobe_n;
    logic [11:0] conv0_result, conv1_result, base, old;
    logic [2:0]  result_select_lines, hold_pairs;
    logic [1:0]  conv_pair;
    logic [15:0] data_out, data_oe, w;
    int          miscompares, tests_run, k, seed;
    sacs_scheduler sacs_scheduler_inst (.clock(clock), .rst_n(rst_n), .conv_clk(conv_clk),
        .pair_a_sample_request_n(pair_a_sample_request_n),
        .pair_b_sample_request_n(pair_b_sample_request_n),
        .pair_c_sample_request_n(pair_c_sample_request_n),
        .conv0_result(conv0_result), .conv1_result(conv1_result),
        .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
        .result_select_lines(result_select_lines), .busy_n(busy_n), .hold_pairs(hold_pairs),
        .conv_pair(conv_pair), .data_out(data_out), .data_oe(data_oe));
    sacs_host_model sacs_host_model_inst (.clock(clock), .rst_n(rst_n), .conv_pair(conv_pair),
        .base(base), .conv_clk(conv_clk), .conv0_result(conv0_result),
        .conv1_result(conv1_result));
    // ********************************
    // Helpers
    // ********************************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [15:0] word_of(input logic [2:0] n, input logic [11:0] bs);
        return {1'b1, n, bs + {9'h000, n}};
    endfunction
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 2000 && busy_n !== lvl; i++) @(negedge clock);
        check("busy_n", {15'h0000, busy_n}, {15'h0000, lvl});
    endtask
    task automatic start(input logic [1:0] p);
        wait_busy(1'b1);
        wait_busy(1'b0);
        check("conv_pair", {14'h0000, conv_pair}, {14'h0000, p});
        check("hold_pairs", {15'h0000, hold_pairs[p]}, 16'h0001);
    endtask
    // Address set 12 ns ahead, strobe low len clocks, then high 32 ns
    task automatic do_read(input logic [2:0] sel, input int len, output logic [15:0] wd,
                           output logic bz);
        result_select_lines = sel;
        repeat (3) @(negedge clock);
        chip_select_n = 1'b0;
        read_strobe_n = 1'b0;
        repeat (len) @(negedge clock);
        wd = data_out;
        bz = busy_n;
        check("oe_on", data_oe, 16'hFFFF);
        chip_select_n = 1'b1;
        read_strobe_n = 1'b1;
        repeat (8) @(negedge clock);
        check("oe_off", data_oe, 16'h0000);
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ********************************
    // Scenarios
    // ********************************
    initial begin
        {rst_n, result_select_lines} = 4'h0;
        {pair_a_sample_request_n, pair_b_sample_request_n, pair_c_sample_request_n} = 3'h7;
        {chip_select_n, read_strobe_n} = 2'h3;
        seed = $urandom(32'h1D01);
        base = 12'($urandom);
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        check("rst", {busy_n, data_oe[0], hold_pairs, 11'h000}, 16'h8000);
        repeat ($urandom_range(20, 6)) @(negedge clock);
        pair_b_sample_request_n = 1'b0;
        start(2'h1);
        @(posedge conv_clk);
        repeat (4) @(negedge clock);
        {pair_a_sample_request_n, pair_c_sample_request_n} = 2'h0;
        repeat (8) @(negedge clock);
        {pair_a_sample_request_n, pair_c_sample_request_n, pair_b_sample_request_n} = 3'h7;
        repeat (4) @(negedge clock);
        pair_b_sample_request_n = 1'b0;
        start(2'h0);
        start(2'h2);
        wait_busy(1'b1);
        extra = 1'b0;
        repeat (1500) @(negedge clock) if (busy_n !== 1'b1) extra = 1'b1;
        check("extra", {15'h0000, extra}, 16'h0000);
        pair_b_sample_request_n = 1'b1;
        for (int n = 0; n < 7; n++) begin
            k = (n < 2) ? n + 2 : (n < 4) ? n - 2 : n;
            do_read(3'h7, 8, w, b);
            check("fifo", w, (n == 6) ? 16'h0000 : word_of(3'(k), base));
        end
        for (int n = 0; n < 6; n++) begin
            do_read(3'(n), 8, w, b);
            check("direct", w, word_of(3'(n), base));
        end
        for (int n = 0; n < 6; n++) begin
            do_read(3'h6, 8, w, b);
            check("cycle", w, word_of(3'(n), base));
        end
        old = base;
        base = 12'($urandom);
        repeat (50) @(negedge clock);
        pair_b_sample_request_n = 1'b0;
        start(2'h1);
        pair_b_sample_request_n = 1'b1;
        repeat (380 + $urandom_range(9, 0)) @(negedge clock);
        do_read(3'h2, 40, w, b);
        check("prev", w, word_of(3'h2, old));
        check("defer", {15'h0000, b}, 16'h0000);
        wait_busy(1'b1);
        do_read(3'h3, 8, w, b);
        check("new", w, word_of(3'h3, base));
        repeat (50) @(negedge clock);
        pair_b_sample_request_n = 1'b0;
        start(2'h1);
        pair_b_sample_request_n = 1'b1;
        // C commits while B converts, A over two conversion clocks later: C must lead
        pair_c_sample_request_n = 1'b0;
        repeat (72) @(negedge clock);
        pair_a_sample_request_n = 1'b0;
        repeat (8) @(negedge clock);
        {pair_a_sample_request_n, pair_c_sample_request_n} = 2'h3;
        start(2'h2);
        start(2'h0);
        repeat (20) @(negedge clock);
        rst_n = 1'b0;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        check("abort", {busy_n, hold_pairs, 12'h000}, 16'h8000);
        do_read(3'h7, 8, w, b);
        check("cleared", w, 16'h0000);
        do_read(3'h2, 8, w, b);
        check("cleared_reg", w, 16'h2000);
        print_verdict();
    end
    // Cut a hang well past the expected run of about 5000 clocks
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        print_verdict();
    end
endmodule
bind sacs_scheduler sacs_scheduler_monitor sacs_scheduler_monitor_inst (.clock(clock),
    .rst_n(rst_n), .pair_a_sample_request_n(pair_a_sample_request_n),
    .pair_b_sample_request_n(pair_b_sample_request_n),
    .pair_c_sample_request_n(pair_c_sample_request_n), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .busy_n(busy_n), .hold_pairs(hold_pairs),
    .conv_pair(conv_pair), .data_out(data_out), .data_oe(data_oe));
